// [rtl/angc_pkg.sv]
package angc_pkg;

  // Register addresses on the management interface
  localparam logic [4:0] ANGC_ADDR_EXPANSION = 5'h06;
  localparam logic [4:0] ANGC_ADDR_NP_TX = 5'h07;
  localparam logic [4:0] ANGC_ADDR_PARTNER_NP = 5'h08;
  localparam logic [4:0] ANGC_ADDR_GIG_CTRL = 5'h09;

  // Expansion register bit positions
  localparam int ANGC_EXP_PD_FAULT = 4;
  localparam int ANGC_EXP_LP_NP_ABLE = 3;
  localparam int ANGC_EXP_LOCAL_NP = 2;
  localparam int ANGC_EXP_PAGE_RX = 1;
  localparam int ANGC_EXP_LP_AN_ABLE = 0;

  // Reset values and the fixed local next page bit
  localparam logic ANGC_RST_MSG_PAGE = 1'h1;
  localparam logic [10:0] ANGC_RST_NP_CODE = 11'h3FF;
  localparam logic [2:0] ANGC_RST_TEST_MODE = 3'h0;
  localparam logic [15:0] ANGC_RST_WORD = 16'h0000;
  localparam logic ANGC_LOCAL_NP_CAPABLE = 1'h1;

  // One next page link code word, bit 15 down to bit 0
  typedef struct packed {
    logic more_pages;
    logic ack;
    logic msg_page;
    logic ack2;
    logic toggle;
    logic [10:0] code;
  } angc_page_s;

  // Gigabit control, upper byte of the register
  typedef struct packed {
    logic [2:0] test_mode;
    logic ms_manual;
    logic ms_master;
    logic port_multi;
    logic adv_full;
    logic adv_half;
  } angc_gig_ctrl_s;

  typedef enum logic [2:0] {
    ANGC_TM_NORMAL,
    ANGC_TM_TX_WAVEFORM,
    ANGC_TM_MASTER_JITTER,
    ANGC_TM_SLAVE_JITTER,
    ANGC_TM_DISTORTION,
    ANGC_TM_RESERVED
  } angc_test_mode_e;

endpackage : angc_pkg

// [rtl/angc_regs.sv]
`timescale 1ns/100ps
// Behaviour
// - Expansion bits 15:5 read zero, writes ignored
// - Parallel detection fault latches high in bit 4
// - Bit 3 shows partner next page capability
// - Bit 2 reads one: local next page capable
// - Bit 1 latches high on each new page
// - Bit 0 shows partner auto-negotiation ability
// - Host sets more-pages, message page, compliance bits
// - Toggle bit is inverse of last sent toggle
// - Host writes 11-bit code, resets to 3FF
// - Received partner page stored read-only, resets zero
// - Bits 15:13 decode test mode, reserved codes
// - Bit 12 selects manual master/slave configuration
// - Bit 11 master/slave value, gated by manual except in o_tech_ext
// - Bit 10 port type steers automatic preference
// - Bit 9 gates gigabit full-duplex advertisement
// - Bit 8 half-duplex advert, unsupported, keep zero
// - Control bits 12:8 extend base page abilities
module angc_regs (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // Management register access
  input wire logic [4:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic i_reg_rd,
  output logic [15:0] o_reg_rdata,
  output logic o_reg_rvalid,
  // Status from the auto-negotiation engine
  input wire logic i_pd_fault,
  input wire logic i_lp_np_able,
  input wire logic i_lp_an_able,
  input wire logic i_page_rx,
  input wire angc_pkg::angc_page_s i_page_word,
  input wire logic i_lcw_sent,
  input wire logic i_lcw_toggle,
  // Controls to the auto-negotiation engine
  output angc_pkg::angc_page_s o_np_tx,
  output angc_pkg::angc_test_mode_e o_test_mode,
  output logic o_test_reserved,
  output logic o_ms_manual,
  output logic o_ms_master,
  output logic o_prefer_master,
  output logic o_adv_1000_full,
  output logic o_adv_1000_half,
  output logic [4:0] o_tech_ext
);
  import angc_pkg::*;

  logic pd_fault_q;
  logic page_rx_q;
  logic toggle_q;
  logic np_more_q;
  logic np_msg_q;
  logic np_ack2_q;
  logic [10:0] np_code_q;
  angc_page_s lp_page_q;
  angc_gig_ctrl_s gig_q;
  logic [15:0] rdata_d;
  logic rd_exp;

  function automatic logic hit(input logic [4:0] addr, input logic [4:0] reg_addr);
    hit = (addr == reg_addr);
  endfunction : hit

  assign rd_exp = i_reg_rd && hit(i_reg_addr, ANGC_ADDR_EXPANSION);

  // Set beats the read clear so no event is lost
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      pd_fault_q <= 1'b0;
      page_rx_q <= 1'b0;
    end else begin
      pd_fault_q <= i_pd_fault | (pd_fault_q & ~rd_exp);
      page_rx_q <= i_page_rx | (page_rx_q & ~rd_exp);
    end
  end

  // Page captured on the same edge as its flag
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      lp_page_q <= angc_page_s'(ANGC_RST_WORD);
    end else if (i_page_rx) begin
      lp_page_q <= i_page_word;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      toggle_q <= 1'b0;
    end else if (i_lcw_sent) begin
      toggle_q <= ~i_lcw_toggle;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      np_more_q <= 1'b0;
      np_msg_q <= ANGC_RST_MSG_PAGE;
      np_ack2_q <= 1'b0;
      np_code_q <= ANGC_RST_NP_CODE;
    end else if (i_reg_wr && hit(i_reg_addr, ANGC_ADDR_NP_TX)) begin
      np_more_q <= i_reg_wdata[15];
      np_msg_q <= i_reg_wdata[13];
      np_ack2_q <= i_reg_wdata[12];
      np_code_q <= i_reg_wdata[10:0];
    end
  end

  // Low byte is not stored; host keeps it zero
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      gig_q <= '{test_mode: ANGC_RST_TEST_MODE, default: 1'b0};
    end else if (i_reg_wr && hit(i_reg_addr, ANGC_ADDR_GIG_CTRL)) begin
      gig_q <= angc_gig_ctrl_s'(i_reg_wdata[15:8]);
    end
  end

  always_comb begin
    rdata_d = 16'h0000;
    case (i_reg_addr)
      ANGC_ADDR_EXPANSION: begin
        rdata_d[ANGC_EXP_PD_FAULT] = pd_fault_q;
        rdata_d[ANGC_EXP_LP_NP_ABLE] = i_lp_np_able;
        rdata_d[ANGC_EXP_LOCAL_NP] = ANGC_LOCAL_NP_CAPABLE;
        rdata_d[ANGC_EXP_PAGE_RX] = page_rx_q;
        rdata_d[ANGC_EXP_LP_AN_ABLE] = i_lp_an_able;
      end
      ANGC_ADDR_NP_TX: begin
        rdata_d = o_np_tx;
      end
      ANGC_ADDR_PARTNER_NP: begin
        rdata_d = lp_page_q;
      end
      ANGC_ADDR_GIG_CTRL: begin
        rdata_d[15:8] = gig_q;
      end
      default: begin
        rdata_d = 16'h0000;
      end
    endcase
  end

  // Read data registered; flags clear on this same edge
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_reg_rdata <= 16'h0000;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd) begin
        o_reg_rdata <= rdata_d;
      end
    end
  end

  assign o_np_tx = '{more_pages: np_more_q, ack: 1'b0, msg_page: np_msg_q,
                     ack2: np_ack2_q, toggle: toggle_q, code: np_code_q};

  always_comb begin
    o_test_reserved = 1'b0;
    case (gig_q.test_mode)
      3'h0: o_test_mode = ANGC_TM_NORMAL;
      3'h1: o_test_mode = ANGC_TM_TX_WAVEFORM;
      3'h2: o_test_mode = ANGC_TM_MASTER_JITTER;
      3'h3: o_test_mode = ANGC_TM_SLAVE_JITTER;
      3'h4: o_test_mode = ANGC_TM_DISTORTION;
      default: begin
        o_test_mode = ANGC_TM_RESERVED;
        o_test_reserved = 1'b1;
      end
    endcase
  end

  assign o_ms_manual = gig_q.ms_manual;
  // Value bit masked when not manual
  assign o_ms_master = gig_q.ms_manual & gig_q.ms_master;
  assign o_prefer_master = gig_q.ms_manual ? gig_q.ms_master : gig_q.port_multi;
  assign o_adv_1000_full = gig_q.adv_full;
  // Passed through as written; the engine does not run half duplex
  assign o_adv_1000_half = gig_q.adv_half;
  assign o_tech_ext = {gig_q.ms_manual, gig_q.ms_master, gig_q.port_multi,
                       gig_q.adv_full, gig_q.adv_half};

endmodule : angc_regs

// [verification/angc_regs_monitor.sv]
`timescale 1ns/100ps
module angc_regs_monitor (
  // Clock, reset and causes
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic [4:0] i_reg_addr,
  input wire logic i_reg_rd,
  input wire logic i_pd_fault,
  input wire logic i_page_rx,
  // Outputs watched
  input wire logic [15:0] o_reg_rdata,
  input wire logic o_reg_rvalid,
  input wire angc_pkg::angc_test_mode_e o_test_mode,
  input wire logic o_test_reserved,
  input wire logic o_ms_manual,
  input wire logic o_ms_master,
  input wire logic o_adv_1000_full,
  input wire logic [4:0] o_tech_ext
);
  import angc_pkg::*;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  sequence s_rd_exp;
    i_reg_rd && i_reg_addr == ANGC_ADDR_EXPANSION;
  endsequence
  // No read in between, so nothing may have cleared the flag
  property p_latch(ev, int b);
    ev ##1 !i_reg_rd ##1 s_rd_exp |=> o_reg_rdata[b];
  endproperty
  rd_valid_a: assert property (i_reg_rd |=> o_reg_rvalid) else $error("read unanswered");
  exp_fixed_a: assert property (s_rd_exp |=> o_reg_rdata[15:5] == 11'h000 && o_reg_rdata[2])
    else $error("expansion fixed bits wrong");
  fault_latch_a: assert property (p_latch(i_pd_fault, 4)) else $error("fault flag lost");
  page_latch_a: assert property (p_latch(i_page_rx, 1)) else $error("page flag lost");
  ms_master_a: assert property (o_ms_master |-> o_ms_manual) else $error("master without manual");
  tm_rsvd_a: assert property (o_test_reserved == (o_test_mode == ANGC_TM_RESERVED))
    else $error("reserved test mode flag wrong");
  ext_manual_a: assert property (o_tech_ext[4] == o_ms_manual) else $error("ext bit 4 wrong");
  ext_full_a: assert property (o_tech_ext[1] == o_adv_1000_full) else $error("ext bit 1 wrong");
endmodule : angc_regs_monitor
bind angc_regs angc_regs_monitor mon (.*);

// [verification/angc_lp_model.sv]
`timescale 1ns/100ps
module angc_lp_model (
  // Clock
  input wire logic i_ref_clk,
  // Received page towards the block
  output angc_pkg::angc_page_s o_page_word,
  output logic o_page_rx
);
  import angc_pkg::*;
  initial begin
    o_page_word = 16'h0000;
    o_page_rx = 1'b0;
  end
  task automatic page(input angc_page_s w);
    @(posedge i_ref_clk) #1;
    o_page_word = w;
    o_page_rx = 1'b1;
    @(posedge i_ref_clk) #1;
    o_page_rx = 1'b0;
    // Word is stale once the pulse has gone
    o_page_word = ~w;
  endtask : page
endmodule : angc_lp_model

// [verification/tb_autoneg_nextpage_gig_ctrl_regs.sv]
`timescale 1ns/100ps
module tb_autoneg_nextpage_gig_ctrl_regs;
  import angc_pkg::*;
  logic i_ref_clk, i_sys_rst, i_reg_wr, i_reg_rd, i_pd_fault, i_lp_np_able, i_lp_an_able;
  logic i_lcw_sent, i_lcw_toggle, o_reg_rvalid, page_rx, o_test_reserved, o_ms_manual, o_ms_master;
  logic o_prefer_master, o_adv_1000_full, o_adv_1000_half;
  logic [4:0] i_reg_addr, o_tech_ext;
  logic [15:0] i_reg_wdata, o_reg_rdata, w, exp_q[$];
  angc_page_s page_word, o_np_tx;
  angc_test_mode_e o_test_mode;
  int err_total = 0;
  int cmp_count = 0;
  angc_regs dut (.*, .i_page_rx(page_rx), .i_page_word(page_word));
  angc_lp_model lp (.i_ref_clk(i_ref_clk), .o_page_word(page_word), .o_page_rx(page_rx));
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] x);
    cmp_count++;
    if (s !== x) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", n, x, s);
    end
  endtask : chk
  task automatic end_sim;
    $display("compares %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim
  task automatic acc(input logic wr, input logic [4:0] a, input logic [15:0] d);
    if (!wr) exp_q.push_back(d);
    @(posedge i_ref_clk) #1;
    {i_reg_wr, i_reg_rd, i_reg_addr, i_reg_wdata} = {wr, !wr, a, d};
    @(posedge i_ref_clk) #1;
    {i_reg_wr, i_reg_rd} = 2'h0;
  endtask : acc
  initial begin
    i_ref_clk = 1'b0;
    forever #50 i_ref_clk = ~i_ref_clk;
  end
  always @(posedge i_ref_clk) if (o_reg_rvalid === 1'b1) chk("rdata", o_reg_rdata, exp_q.pop_front());
  initial begin
    #300000;
    err_total++;
    end_sim;
  end
  initial begin
    {i_sys_rst, i_reg_wr, i_reg_rd, i_reg_addr, i_reg_wdata} = {1'b1, 23'h0};
    {i_pd_fault, i_lp_np_able, i_lp_an_able, i_lcw_sent, i_lcw_toggle} = 5'h00;
    w = $urandom(32'hFE3699B4);
    repeat (4) @(posedge i_ref_clk);
    #1 i_sys_rst = 1'b0;
    acc(0, 5'h06, 16'h0004);
    acc(0, 5'h07, 16'h23FF);
    acc(0, 5'h08, 16'h0000);
    acc(1, 5'h06, 16'hFFFF);
    acc(1, 5'h1F, 16'hFFFF);
    acc(0, 5'h06, 16'h0004);
    acc(0, 5'h1F, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      w = {i[2:0], 13'($urandom)} & 16'hFE00;
      acc(1, 5'h09, w);
      chk("gig", 16'({o_test_mode, o_test_reserved, o_ms_manual, o_ms_master, o_prefer_master, o_adv_1000_full,
        o_adv_1000_half, o_tech_ext}), 16'({i < 5 ? i[2:0] : 3'h5, i > 4, w[12], w[12] & w[11],
        w[12] ? w[11] : w[10], w[9:8], w[12:8]}));
      acc(0, 5'h09, w);
    end
    for (int i = 0; i < 2; i++) begin
      @(posedge i_ref_clk) #1 {i_lcw_sent, i_lcw_toggle} = {1'b1, i[0]};
      @(posedge i_ref_clk) #1 {i_lcw_sent, i_lcw_toggle} = {1'b0, ~i[0]};
      w = 16'($urandom);
      acc(1, 5'h07, w);
      w = {w[15], 1'b0, w[13:12], ~i[0], w[10:0]};
      chk("np_tx", o_np_tx, w);
      acc(0, 5'h07, w);
    end
    {i_lp_np_able, i_lp_an_able} = 2'h3;
    w = 16'($urandom);
    lp.page(w);
    acc(0, 5'h08, w);
    acc(0, 5'h06, 16'h000F);
    acc(0, 5'h06, 16'h000D);
    @(posedge i_ref_clk) #1 i_pd_fault = 1'b1;
    @(posedge i_ref_clk) #1 i_pd_fault = 1'b0;
    acc(0, 5'h06, 16'h001D);
    acc(0, 5'h06, 16'h000D);
    repeat (3) @(posedge i_ref_clk);
    end_sim;
  end
endmodule : tb_autoneg_nextpage_gig_ctrl_regs
